// >>> hdl/can_status_ctrl.sv
/*
 * CAN controller status block: mailbox search, error counters and
 * error state, error flags and bus-off recovery, behind AXI4-Lite.
 * Assumes mailbox flags and error pulses come from the CAN core,
 * synchronous to ref_clk_i.
 */
// What this block does
// RULE1: two-bit field selects rx, tx, lost, channel search.
// RULE2: rx search shows lowest mailbox with new data.
// RULE3: nothing pending sets the search-empty flag.
// RULE4: FIFO mode rx search reports mailbox 12.
// RULE5: tx search shows lowest sent mailbox, else empty.
// RULE6: FIFO mode tx search skips FIFO mailboxes.
// RULE7: lost search lowest lost mailbox; FIFO lost is 12.
// RULE8: channel search reads advance through written pattern.
// RULE9: errors bump transmit or receive counter.
// RULE10: either counter at 96 sets warning flag.
// RULE11: either counter at 128 means error-passive.
// RULE12: transmit counter at 256 enters bus-off.
// RULE13: error sources interrupt only when enabled.
// RULE14: software sets enables only in reset mode; code accepts enable writes in any mode.
// RULE15: status shows passive and bus-off state bits.
// RULE16: error and wake share vector; source bit.
// RULE17: recovery mode 00 returns to error-active.
// RULE18: forced return bit recovers now, self-clears.
// RULE19: mode 01 halts on reaching bus-off.
// RULE20: mode 10 halts after recovery, sets flag.
// RULE21: recovery needs 128 runs of 11 recessive bits.
// RULE22: mode 11 halts on software request in bus-off.
`timescale 1ns/1ps
`include "can_status_regs.svh"
module can_status_ctrl #(
	parameter int MAILBOXES = 16,
	parameter int ADDR_W = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic [ADDR_W-1:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [ADDR_W-1:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	input wire logic [MAILBOXES-1:0] rx_new_flag_i,
	input wire logic [MAILBOXES-1:0] tx_done_flag_i,
	input wire logic [MAILBOXES-1:0] rx_overrun_flag_i,
	input wire logic rx_fifo_lost_flag_i,
	input wire logic rx_fifo_empty_i,
	input wire logic fifo_mode_i,
	input wire logic tx_error_i,
	input wire logic rx_error_i,
	input wire logic recessive_run_i,
	input wire logic wakeup_i,
	output logic irq_o,
	output logic [1:0] operating_mode_o,
	output logic passive_o,
	output logic busoff_o,
	output logic comm_enable_o
);

	initial begin
		if (MAILBOXES != 16 || ADDR_W < 6) begin
			$error("can_status_ctrl: needs 16 mailboxes, 6 address bits");
		end
	end

	// ****************************************************************
	// Registers and internal state.
	// ****************************************************************
	can_status_pkg::search_mode_type search_mode;
	can_status_pkg::recov_mode_type recovery_mode_field;
	can_status_pkg::err_state_type err_state;
	can_status_pkg::err_state_type prev_state;
	can_status_pkg::err_state_type next_state;
	logic forced_return_bit;
	logic [15:0] channel_pattern;
	logic [4:0] err_irq_enable;
	logic [4:0] err_irq_flag;
	logic [2:0] err_irq_priority;
	logic [1:0] irq_enable;
	logic [3:0] search_result;
	logic search_empty_flag;
	logic err_source;
	logic warn_prev;
	logic recov_event;
	logic resume_wait;
	logic [6:0] recov_runs;
	logic [8:0] tec;
	logic [8:0] rec;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic wr_hit;
	logic wr_fire;
	logic rd_fire;
	logic [15:0] next_vec;
	logic [3:0] found_idx;
	logic found_none;
	logic warn_now;
	logic busoff;
	logic leave_normal;
	logic leave_forced;
	logic halt_prog;
	logic leave_busoff;
	logic ctrl_wr;
	logic [4:0] events;
	logic err_pending;
	logic wake_pending;

	// Byte-lane merge of a write into an existing register value.
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// ****************************************************************
	// AXI4-Lite slave handshakes.
	// ****************************************************************

	// Address and data are taken in either order; the write is done
	// once both are held. The bus must stay idle while ce_i is low.
	assign wr_fire = ce_i && !awready_o && !wready_o && !bvalid_o;
	assign rd_fire = ce_i && arvalid_i && arready_o;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			awready_o <= 1'b1;
			wready_o <= 1'b1;
			bvalid_o <= 1'b0;
			bresp_o <= `RESP_OKAY;
			wr_addr <= '0;
			wr_data <= 32'h0;
			wr_strb <= 4'h0;
		end else if (ce_i) begin
			if (awvalid_i && awready_o) begin
				awready_o <= 1'b0;
				wr_addr <= awaddr_i;
			end
			if (wvalid_i && wready_o) begin
				wready_o <= 1'b0;
				wr_data <= wdata_i;
				wr_strb <= wstrb_i;
			end
			if (wr_fire) begin
				bvalid_o <= 1'b1;
				bresp_o <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid_o && bready_i) begin
				bvalid_o <= 1'b0;
				awready_o <= 1'b1;
				wready_o <= 1'b1;
			end
		end
	end

	// Read data are captured at the address handshake.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			arready_o <= 1'b1;
			rvalid_o <= 1'b0;
			rdata_o <= 32'h0;
			rresp_o <= `RESP_OKAY;
		end else if (ce_i) begin
			if (rd_fire) begin
				arready_o <= 1'b0;
				rvalid_o <= 1'b1;
				rdata_o <= rd_mux;
				rresp_o <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_o && rready_i) begin
				rvalid_o <= 1'b0;
				arready_o <= 1'b1;
			end
		end
	end

	// Read decode; unmapped addresses read zero with an error answer.
	always_comb begin
		rd_mux = 32'h0;
		rd_hit = 1'b1;
		unique case (8'(araddr_i))
		`ADDR_CONTROL: rd_mux = {26'h0, 1'b0, recovery_mode_field,
			1'b0, operating_mode_o};
		`ADDR_STATUS: rd_mux = {25'h0, resume_wait,
			operating_mode_o == can_status_pkg::OP_HALT, err_source,
			warn_now, busoff, passive_o, search_empty_flag}; // see RULE15
		`ADDR_SEARCH_MODE: rd_mux = {30'h0, search_mode};
		`ADDR_SEARCH_RESULT: rd_mux = {28'h0, search_result};
		`ADDR_CHANNEL: rd_mux = {16'h0, channel_pattern};
		`ADDR_ERR_ENABLE: rd_mux = {27'h0, err_irq_enable};
		`ADDR_ERR_FLAG: rd_mux = {27'h0, err_irq_flag}; // see RULE13
		`ADDR_COUNTERS: rd_mux = {7'h0, rec, 7'h0, tec};
		`ADDR_ERR_PRIORITY: rd_mux = {29'h0, err_irq_priority};
		`ADDR_IRQ_ENABLE: rd_mux = {30'h0, irq_enable};
		default: rd_hit = 1'b0;
		endcase
	end

	assign wr_hit = (8'(wr_addr) == `ADDR_CONTROL) ||
		(8'(wr_addr) == `ADDR_SEARCH_MODE) ||
		(8'(wr_addr) == `ADDR_CHANNEL) ||
		(8'(wr_addr) == `ADDR_ERR_ENABLE) ||
		(8'(wr_addr) == `ADDR_ERR_FLAG) ||
		(8'(wr_addr) == `ADDR_ERR_PRIORITY) ||
		(8'(wr_addr) == `ADDR_IRQ_ENABLE) ||
		(8'(wr_addr) == `ADDR_STATUS) ||
		(8'(wr_addr) == `ADDR_SEARCH_RESULT) ||
		(8'(wr_addr) == `ADDR_COUNTERS);
	assign ctrl_wr = wr_fire && 8'(wr_addr) == `ADDR_CONTROL && wr_strb[0];

	// ****************************************************************
	// Mailbox and channel search.
	// ****************************************************************

	// FIFO mailboxes fold into one entry at 12, or vanish for transmit.
	always_comb begin
		next_vec = 16'h0;
		unique case (search_mode) // see RULE1
		can_status_pkg::SEARCH_RX: begin
			next_vec = rx_new_flag_i; // see RULE2
			if (fifo_mode_i) begin
				next_vec = rx_new_flag_i & `RX_FIFO_MASK;
				next_vec[`RX_FIFO_MAILBOX] = !rx_fifo_empty_i; // see RULE4
			end
		end
		can_status_pkg::SEARCH_TX: begin
			next_vec = tx_done_flag_i; // see RULE5
			if (fifo_mode_i) begin
				next_vec = tx_done_flag_i & `TX_NORMAL_MASK; // see RULE6
			end
		end
		can_status_pkg::SEARCH_LOST: begin
			next_vec = rx_overrun_flag_i; // see RULE7
			if (fifo_mode_i) begin
				next_vec = rx_overrun_flag_i & `RX_FIFO_MASK;
				next_vec[`RX_FIFO_MAILBOX] = rx_fifo_lost_flag_i;
			end
		end
		can_status_pkg::SEARCH_CHANNEL: next_vec = channel_pattern;
		endcase
	end

	lowest_bit_finder #(
		.WIDTH(16),
		.IDX_W(4)
	) finder (
		.vec_i(next_vec),
		.idx_o(found_idx),
		.none_o(found_none)
	);

	// The result follows the flags one cycle late; software clearing a
	// flag therefore shows the next mailbox on its following read.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			search_result <= 4'h0;
			search_empty_flag <= 1'b1;
		end else if (ce_i) begin
			search_result <= found_idx;
			search_empty_flag <= found_none; // see RULE3
		end
	end

	// Search mode and channel pattern. A read of the result in channel
	// mode retires the channel just read; a same-edge write wins.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			search_mode <= can_status_pkg::SEARCH_RX;
			channel_pattern <= 16'h0;
		end else if (ce_i) begin
			if (rd_fire && 8'(araddr_i) == `ADDR_SEARCH_RESULT &&
					search_mode == can_status_pkg::SEARCH_CHANNEL &&
					!search_empty_flag) begin
				channel_pattern[search_result] <= 1'b0; // see RULE8
			end
			if (wr_fire && 8'(wr_addr) == `ADDR_CHANNEL) begin
				channel_pattern <= 16'(merge({16'h0, channel_pattern},
					wr_data, wr_strb));
			end
			if (wr_fire && 8'(wr_addr) == `ADDR_SEARCH_MODE && wr_strb[0]) begin
				search_mode <= can_status_pkg::search_mode_type'(wr_data[1:0]);
			end
		end
	end

	// ****************************************************************
	// Error counters and error state.
	// ****************************************************************
	assign busoff = err_state == can_status_pkg::ERR_BUSOFF;
	assign warn_now = tec >= `WARN_LIMIT || rec >= `WARN_LIMIT;
	assign leave_forced = busoff && forced_return_bit; // see RULE18
	assign halt_prog = busoff && ctrl_wr &&
		recovery_mode_field == can_status_pkg::RECOV_HALT_PROG &&
		wr_data[1:0] == can_status_pkg::OP_HALT; // see RULE22
	assign leave_normal = busoff && recessive_run_i &&
		recov_runs == `RECOV_RUNS_LAST; // see RULE21
	assign leave_busoff = leave_normal || leave_forced || halt_prog;

	// Counting stops in bus-off; leaving it starts both counters over.
	error_counter #(
		.WIDTH(9)
	) tx_counter (
		.clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.inc_i(tx_error_i && !busoff), // see RULE9
		.clr_i(leave_busoff),
		.count_o(tec)
	);

	error_counter #(
		.WIDTH(9)
	) rx_counter (
		.clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.inc_i(rx_error_i && !busoff), // see RULE9
		.clr_i(leave_busoff),
		.count_o(rec)
	);

	// Counters never fall here, so passive lasts until bus-off clears.
	always_comb begin
		next_state = err_state;
		unique case (err_state)
		can_status_pkg::ERR_ACTIVE, can_status_pkg::ERR_PASSIVE: begin
			if (tec >= `BUSOFF_LIMIT) begin
				next_state = can_status_pkg::ERR_BUSOFF; // see RULE12
			end else if (tec >= `PASSIVE_LIMIT || rec >= `PASSIVE_LIMIT) begin
				next_state = can_status_pkg::ERR_PASSIVE; // see RULE11
			end
		end
		can_status_pkg::ERR_BUSOFF: begin
			if (leave_busoff) begin
				next_state = can_status_pkg::ERR_ACTIVE; // see RULE17
			end
		end
		default: next_state = can_status_pkg::ERR_ACTIVE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			err_state <= can_status_pkg::ERR_ACTIVE;
			prev_state <= can_status_pkg::ERR_ACTIVE;
			warn_prev <= 1'b0;
			recov_runs <= 7'h0;
			recov_event <= 1'b0;
			resume_wait <= 1'b0;
			passive_o <= 1'b0;
			busoff_o <= 1'b0;
			comm_enable_o <= 1'b1;
		end else if (ce_i) begin
			err_state <= next_state;
			prev_state <= err_state;
			warn_prev <= warn_now;
			passive_o <= next_state == can_status_pkg::ERR_PASSIVE;
			busoff_o <= next_state == can_status_pkg::ERR_BUSOFF;
			recov_runs <= busoff && !leave_busoff ?
				recov_runs + 7'(recessive_run_i) : 7'h0;
			recov_event <= leave_normal &&
				recovery_mode_field == can_status_pkg::RECOV_HALT_END;
			if (leave_forced) begin
				resume_wait <= 1'b1; // see RULE18
			end else if (recessive_run_i) begin
				resume_wait <= 1'b0;
			end
			comm_enable_o <= next_state != can_status_pkg::ERR_BUSOFF &&
				!(leave_forced || (resume_wait && !recessive_run_i));
		end
	end

	// ****************************************************************
	// Control register and bus-off halt handling.
	// ****************************************************************

	// The forced return bit is kept only in bus-off and clears itself
	// once acted upon. Hardware halts overwrite a same-edge write.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			operating_mode_o <= can_status_pkg::OP_RESET;
			recovery_mode_field <= can_status_pkg::RECOV_NORMAL;
			forced_return_bit <= 1'b0;
		end else if (ce_i) begin
			forced_return_bit <= 1'b0;
			if (ctrl_wr) begin
				operating_mode_o <= wr_data[1:0];
				recovery_mode_field <= can_status_pkg::recov_mode_type'(
					wr_data[`CTRL_RECOV_LSB +: 2]); // see RULE17
				forced_return_bit <= busoff && !leave_forced &&
					wr_data[`CTRL_FORCED_BIT];
			end
			if (busoff && prev_state != can_status_pkg::ERR_BUSOFF &&
					recovery_mode_field == can_status_pkg::RECOV_HALT_START) begin
				operating_mode_o <= can_status_pkg::OP_HALT; // see RULE19
			end
			if (leave_normal &&
					recovery_mode_field == can_status_pkg::RECOV_HALT_END) begin
				operating_mode_o <= can_status_pkg::OP_HALT; // see RULE20
			end
		end
	end

	// ****************************************************************
	// Error interrupt flags, enables and the shared request line.
	// ****************************************************************
	assign events = {wakeup_i, recov_event,
		busoff && prev_state != can_status_pkg::ERR_BUSOFF,
		err_state == can_status_pkg::ERR_PASSIVE &&
			prev_state == can_status_pkg::ERR_ACTIVE,
		warn_now && !warn_prev}; // see RULE10

	// Writing 1 clears a flag; an event on the same edge keeps it set.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			err_irq_flag <= 5'h0;
			err_irq_enable <= 5'h0;
			err_irq_priority <= 3'h0;
			irq_enable <= 2'h0;
		end else if (ce_i) begin
			err_irq_flag <= (err_irq_flag & ~((wr_fire &&
				8'(wr_addr) == `ADDR_ERR_FLAG && wr_strb[0]) ?
				wr_data[4:0] : 5'h0)) | events;
			if (wr_fire && wr_strb[0]) begin
				if (8'(wr_addr) == `ADDR_ERR_ENABLE) begin
					err_irq_enable <= wr_data[4:0]; // see RULE14
				end
				if (8'(wr_addr) == `ADDR_ERR_PRIORITY) begin
					err_irq_priority <= wr_data[2:0];
				end
				if (8'(wr_addr) == `ADDR_IRQ_ENABLE) begin
					irq_enable <= wr_data[1:0];
				end
			end
		end
	end

	assign err_pending = |(err_irq_flag[3:0] & err_irq_enable[3:0]) &&
		irq_enable[0] && err_irq_priority != 3'h0; // see RULE13
	assign wake_pending = err_irq_flag[`FLAG_WAKE] &&
		err_irq_enable[`FLAG_WAKE] && irq_enable[1] &&
		err_irq_priority != 3'h0;

	// One request line serves both error and wake-up causes.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_o <= 1'b0;
			err_source <= 1'b0;
		end else if (ce_i) begin
			irq_o <= err_pending || wake_pending; // see RULE16
			err_source <= err_pending;
		end
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_forced_req;
		ce_i && busoff && forced_return_bit;
	endsequence

	sequence s_forced_done;
		!busoff && resume_wait && !forced_return_bit && !comm_enable_o;
	endsequence

	a_busoff_entry: assert property (ce_i && !busoff && // see RULE12
		tec >= `BUSOFF_LIMIT |=> busoff && busoff_o)
		else $error("bus-off not entered");
	a_passive_entry: assert property (ce_i && !busoff && // see RULE11
		tec < `BUSOFF_LIMIT &&
		(tec >= `PASSIVE_LIMIT || rec >= `PASSIVE_LIMIT) |=> passive_o)
		else $error("passive state missed");
	a_warn_flag: assert property (ce_i && warn_now && // see RULE10
		!warn_prev |=> err_irq_flag[`FLAG_WARN]) else $error("warning lost");
	a_irq_gated: assert property (ce_i && // see RULE13
		err_irq_enable == 5'h0 |=> !irq_o)
		else $error("interrupt without enable");
	a_rx_lowest: assert property (ce_i && // see RULE2
		search_mode == can_status_pkg::SEARCH_RX && !fifo_mode_i &&
		rx_new_flag_i[4:0] == 5'h10 |=> search_result == 4'h4 &&
		!search_empty_flag) else $error("rx search not lowest");
	a_empty_set: assert property (ce_i && // see RULE3
		next_vec == 16'h0 |=> search_empty_flag)
		else $error("empty flag missed");
	a_fifo_rx12: assert property (ce_i && fifo_mode_i && // see RULE4
		search_mode == can_status_pkg::SEARCH_RX && !rx_fifo_empty_i &&
		rx_new_flag_i[11:0] == 12'h0 |=> search_result == `RX_FIFO_MAILBOX)
		else $error("fifo mailbox not 12");
	a_tx_fifo_skip: assert property (ce_i && fifo_mode_i && // see RULE6
		search_mode == can_status_pkg::SEARCH_TX && tx_done_flag_i[7:0] == 8'h0
		|=> search_empty_flag) else $error("tx fifo searched");
	a_forced_return: assert property (s_forced_req // see RULE18
		|=> s_forced_done) else $error("forced return failed");

endmodule : can_status_ctrl

// >>> hdl/can_status_pkg.sv
/*
 * Types shared by the CAN status block: search modes, operating
 * modes, bus-off recovery modes and the error state.
 * Assumes nothing of its surroundings.
 */
package can_status_pkg;

	typedef enum logic [1:0] {
		SEARCH_RX = 2'h0,
		SEARCH_TX = 2'h1,
		SEARCH_LOST = 2'h2,
		SEARCH_CHANNEL = 2'h3
	} search_mode_type;

	typedef enum logic [1:0] {
		OP_OPERATE = 2'h0,
		OP_RESET = 2'h1,
		OP_HALT = 2'h2,
		OP_SLEEP = 2'h3
	} op_mode_type;

	typedef enum logic [1:0] {
		RECOV_NORMAL = 2'h0,
		RECOV_HALT_START = 2'h1,
		RECOV_HALT_END = 2'h2,
		RECOV_HALT_PROG = 2'h3
	} recov_mode_type;

	typedef enum logic [2:0] {
		ERR_ACTIVE = 3'b001,
		ERR_PASSIVE = 3'b010,
		ERR_BUSOFF = 3'b100
	} err_state_type;

endpackage : can_status_pkg

// >>> hdl/can_status_regs.svh
/*
 * Register offsets, field positions, response codes and limits of the
 * CAN status block. Assumes inclusion by bare name from design files.
 */
`ifndef CAN_STATUS_REGS_SVH
`define CAN_STATUS_REGS_SVH

// ****************************************************************
// Byte addresses on the register bus.
// ****************************************************************
`define ADDR_CONTROL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_SEARCH_MODE 8'h08
`define ADDR_SEARCH_RESULT 8'h0c
`define ADDR_CHANNEL 8'h10
`define ADDR_ERR_ENABLE 8'h14
`define ADDR_ERR_FLAG 8'h18
`define ADDR_COUNTERS 8'h1c
`define ADDR_ERR_PRIORITY 8'h20
`define ADDR_IRQ_ENABLE 8'h24

// ****************************************************************
// Field positions and response codes.
// ****************************************************************
`define CTRL_RECOV_LSB 3
`define CTRL_FORCED_BIT 5
`define FLAG_WARN 0
`define FLAG_PASSIVE 1
`define FLAG_BUSOFF 2
`define FLAG_RECOV 3
`define FLAG_WAKE 4
`define COUNT_REC_LSB 16
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************************************
// Error limits and counts.
// ****************************************************************
`define WARN_LIMIT 9'h060
`define PASSIVE_LIMIT 9'h080
`define BUSOFF_LIMIT 9'h100
`define RECOV_RUNS_LAST 7'h7f
`define RX_FIFO_MAILBOX 4'hc
`define RX_FIFO_MASK 16'h0fff
`define TX_NORMAL_MASK 16'h00ff

`endif

// >>> hdl/error_counter.sv
/*
 * Saturating error counter with clear, used for both directions.
 * Assumes inc_i and clr_i are synchronous to clk_i.
 */
`timescale 1ns/1ps
module error_counter #(
	parameter int WIDTH = 9
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic inc_i,
	input wire logic clr_i,
	output logic [WIDTH-1:0] count_o
);

	initial begin
		if (WIDTH < 9) begin
			$error("error_counter: WIDTH must reach the bus-off limit");
		end
	end

	// Clear beats increment; saturation keeps a flood from wrapping.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count_o <= '0;
		end else if (ce_i) begin
			if (clr_i) begin
				count_o <= '0;
			end else if (inc_i && !(&count_o)) begin
				count_o <= count_o + 1'b1;
			end
		end
	end

endmodule : error_counter

// >>> hdl/lowest_bit_finder.sv
/*
 * Finds the lowest set bit of a vector and encodes its position.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module lowest_bit_finder #(
	parameter int WIDTH = 16,
	parameter int IDX_W = 4
) (
	input wire logic [WIDTH-1:0] vec_i,
	output logic [IDX_W-1:0] idx_o,
	output logic none_o
);

	initial begin
		if (WIDTH > (1 << IDX_W)) begin
			$error("lowest_bit_finder: IDX_W too small for WIDTH");
		end
	end

	// Scan downwards so the lowest set bit is the last one written.
	always_comb begin
		idx_o = '0;
		none_o = 1'b1;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (vec_i[i]) begin
				idx_o = IDX_W'(i);
				none_o = 1'b0;
			end
		end
	end

endmodule : lowest_bit_finder

// >>> test/can_bus_node.sv
/*
 * Stands in for the other nodes on the CAN bus: error events and runs
 * of recessive bits. Assumes the bench clock drives clk_i.
 */
`timescale 1ns/1ps
module can_bus_node (
	input wire logic clk_i,
	output logic tx_error_o,
	output logic rx_error_o,
	output logic run_o,
	output logic wake_o
);
	// ****
	// Events
	// ****
	// The bus is quiet until the bench asks for events.
	initial begin
		{tx_error_o, rx_error_o, run_o, wake_o} = '0;
	end
	// One-cycle pulses with a gap, so that two events never merge.
	task automatic burst(input int kind, input int n);
		repeat (n) begin
			@(posedge clk_i);
			tx_error_o <= kind == 0;
			rx_error_o <= kind == 1;
			run_o <= kind == 2;
			wake_o <= kind == 3;
			@(posedge clk_i);
			{tx_error_o, rx_error_o, run_o, wake_o} <= '0;
		end
	endtask : burst
endmodule : can_bus_node

// >>> test/can_status_ctrl_tb.sv
/*
 * Self-checking bench of the CAN status block over AXI4-Lite.
 * Assumes the bus-node model and one 200 MHz clock.
 */
`timescale 1ns/1ps
module can_status_ctrl_tb;
	logic ref_clk_i, rst_b_i, awvalid_i, wvalid_i, bready_i, arvalid_i;
	logic rready_i, fifo_mode_i, rx_fifo_empty_i, rx_fifo_lost_flag_i;
	logic tx_error_i, rx_error_i, recessive_run_i;
	logic [7:0] awaddr_i, araddr_i;
	logic [31:0] wdata_i, rdata_o, rd;
	logic [15:0] rx_new_flag_i, tx_done_flag_i, rx_overrun_flag_i;
	logic [1:0] bresp_o, rresp_o, operating_mode_o;
	logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
	logic passive_o, busoff_o, comm_enable_o, wakeup_i;
	int mismatches = 0;
	int comparisons = 0;
	can_status_ctrl dut (.ref_clk_i, .rst_b_i, .ce_i(1'b1), .awaddr_i,
		.awvalid_i, .awready_o, .wdata_i, .wstrb_i(4'hf), .wvalid_i,
		.wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i,
		.arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i,
		.rx_new_flag_i, .tx_done_flag_i, .rx_overrun_flag_i,
		.rx_fifo_lost_flag_i, .rx_fifo_empty_i, .fifo_mode_i, .tx_error_i,
		.rx_error_i, .recessive_run_i, .wakeup_i, .irq_o,
		.operating_mode_o, .passive_o, .busoff_o, .comm_enable_o);
	can_bus_node node (.clk_i(ref_clk_i), .tx_error_o(tx_error_i),
		.rx_error_o(rx_error_i), .run_o(recessive_run_i),
		.wake_o(wakeup_i));
	// ****
	// Tasks
	// ****
	task automatic end_sim;
		if (mismatches == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One write or read; a read compares the masked word with e.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
		int n;
		@(posedge ref_clk_i);
		awaddr_i <= a;
		araddr_i <= a;
		wdata_i <= d;
		{awvalid_i, wvalid_i, bready_i} <= {3{w}};
		{arvalid_i, rready_i} <= {2{!w}};
		for (n = 0; n < 99; n++) begin
			@(posedge ref_clk_i);
			if (awready_o) awvalid_i <= 1'b0;
			if (wready_o) wvalid_i <= 1'b0;
			if (arready_o) arvalid_i <= 1'b0;
			if (w ? (awready_o || !awvalid_i) && (wready_o || !wvalid_i) :
				arready_o) break;
		end
		for (; n < 99; n++) begin
			@(posedge ref_clk_i);
			if (w ? bvalid_o : rvalid_o) break;
		end
		rd = rdata_o;
		chk(w ? bresp_o : rresp_o, a > 8'h24 ? 2 : 0);
		{bready_i, rready_i} <= '0;
		if (!w) chk(rd & m, e);
		if (n >= 99) begin
			mismatches++;
			end_sim();
		end
	endtask : bus
	// Search modes; flags change just after an edge.
	task automatic t_search;
		rx_new_flag_i <= 16'h0050;
		bus(0, 8'h0c, 0, 32'hf, 32'h4);
		rx_new_flag_i <= 16'h0000;
		bus(0, 8'h04, 0, 32'h1, 32'h1);
		fifo_mode_i <= 1'b1;
		rx_fifo_empty_i <= 1'b0;
		bus(0, 8'h0c, 0, 32'hf, 32'hc);
		bus(1, 8'h08, 1, 0, 0);
		tx_done_flag_i <= 16'h0f00;
		bus(0, 8'h04, 0, 32'h1, 32'h1);
		tx_done_flag_i <= 16'h0f20;
		bus(0, 8'h0c, 0, 32'hf, 32'h5);
		bus(1, 8'h08, 2, 0, 0);
		rx_overrun_flag_i <= 16'h2000;
		rx_fifo_lost_flag_i <= 1'b1;
		bus(0, 8'h0c, 0, 32'hf, 32'hc);
		bus(1, 8'h08, 3, 0, 0);
		bus(1, 8'h10, 32'h12, 0, 0);
		bus(0, 8'h0c, 0, 32'hf, 32'h1);
		bus(0, 8'h0c, 0, 32'hf, 32'h4);
		bus(0, 8'h04, 0, 32'h1, 32'h1);
		bus(0, 8'h30, 0, 32'hffffffff, 32'h0);
	endtask : t_search
	// Counters climb to bus-off; recovery in mode 00 needs 128 runs.
	task automatic t_err;
		bus(1, 8'h20, 1, 0, 0);
		bus(1, 8'h14, 32'h1f, 0, 0);
		bus(1, 8'h24, 1, 0, 0);
		bus(1, 8'h00, 0, 0, 0);
		node.burst(1, 3);
		node.burst(0, 96);
		bus(0, 8'h1c, 0, 32'h01ff01ff, 32'h00030060);
		bus(0, 8'h18, 0, 32'h3, 32'h1);
		node.burst(0, 32);
		bus(0, 8'h04, 0, 32'h1e, 32'h1a);
		chk(irq_o, 1);
		node.burst(0, 128);
		repeat (3) @(posedge ref_clk_i);
		chk(busoff_o, 1);
		bus(0, 8'h18, 0, 32'h4, 32'h4);
		node.burst(2, 127);
		repeat (3) @(posedge ref_clk_i);
		chk(busoff_o, 1);
		node.burst(2, 1);
		repeat (3) @(posedge ref_clk_i);
		chk({busoff_o, passive_o, operating_mode_o}, 0);
		bus(0, 8'h18, 0, 32'h8, 32'h0);
	endtask : t_err
	// Forced return, then halt modes 01, 10 and 11, each from bus-off.
	task automatic t_recov;
		node.burst(0, 256);
		bus(1, 8'h00, 32'h20, 0, 0);
		bus(0, 8'h04, 0, 32'h46, 32'h40);
		chk(comm_enable_o, 0);
		node.burst(2, 1);
		repeat (2) @(posedge ref_clk_i);
		chk(comm_enable_o, 1);
		bus(0, 8'h18, 0, 32'h8, 32'h0);
		bus(1, 8'h00, 32'h09, 0, 0);
		bus(1, 8'h00, 32'h08, 0, 0);
		node.burst(0, 256);
		repeat (3) @(posedge ref_clk_i);
		chk({busoff_o, operating_mode_o}, 3'h6);
		node.burst(2, 128);
		bus(0, 8'h18, 0, 32'h8, 32'h0);
		bus(1, 8'h00, 32'h11, 0, 0);
		bus(1, 8'h00, 32'h10, 0, 0);
		node.burst(0, 256);
		node.burst(2, 128);
		repeat (3) @(posedge ref_clk_i);
		chk({busoff_o, operating_mode_o}, 3'h2);
		bus(0, 8'h18, 0, 32'h8, 32'h8);
		bus(1, 8'h18, 32'h1f, 0, 0);
		bus(1, 8'h00, 32'h19, 0, 0);
		bus(1, 8'h00, 32'h18, 0, 0);
		node.burst(0, 256);
		bus(1, 8'h00, 32'h1a, 0, 0);
		repeat (3) @(posedge ref_clk_i);
		chk({busoff_o, operating_mode_o}, 3'h2);
		bus(0, 8'h18, 0, 32'h8, 32'h0);
		bus(1, 8'h24, 2, 0, 0);
		node.burst(3, 1);
		repeat (3) @(posedge ref_clk_i);
		chk(irq_o, 1);
		bus(0, 8'h04, 0, 32'h10, 32'h0);
	endtask : t_recov
	// A 5 ns clock.
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	// Reset for 8 cycles, then the scenarios.
	initial begin
		{rst_b_i, awvalid_i, wvalid_i, bready_i, arvalid_i} = '0;
		{rready_i, fifo_mode_i, rx_fifo_lost_flag_i} = '0;
		rx_fifo_empty_i = 1'b1;
		{awaddr_i, araddr_i, wdata_i} = '0;
		{rx_new_flag_i, tx_done_flag_i, rx_overrun_flag_i} = '0;
		repeat (8) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		t_search();
		t_err();
		t_recov();
		end_sim();
	end
endmodule : can_status_ctrl_tb
